// File: design/serial_command_framing_crc_cfg.svh
// =====================================================================
// Constants for the serial command framing and checking block
// =====================================================================
// Assumes a 100 MHz system clock and a host that speaks one command at a time.
// Notes on behaviour
// - Link runs 115200 baud, 8 data bits, 2 stop bits, no parity, no flow control.
// - Receiver gives up after 400 ms between two bytes of one command.
// - Multi-byte fields travel least significant byte first.
// - Host starts every exchange; device answers each and waits in between.
// - A frame is a 4-byte identifier, optional data, then a 2-byte checksum; the code takes no checksum when a command has no data.
// - Setter parameters take effect within 1 ms of the acknowledge.
// - Execute only known identifiers with matching checksum; each command used once.
// - Good command is echoed by identifier, then reply data and checksum; the code sends no checksum when the reply has no data.
// - Unknown identifier: drop, answer command-error code, set command-error flag.
// - Known identifier with bad checksum: drop, answer data-error code, set flag.
// - Checksum covers the data section only, never the identifier.
// - Checksum starts 0xFFFF, xor byte, eight right shifts with 0xA001 on carry.
// - A timed-out partial command is dropped and its buffer cleared; the code clears the identifier but leaves data bytes in the buffer.
// - A zero first byte is answered with a single zero byte.
// - Command-error answer is the word 0x63727265, low byte first.
// - Data-error answer is the word 0x64727265, low byte first.
`ifndef SERIAL_COMMAND_FRAMING_CRC_CFG_SVH
`define SERIAL_COMMAND_FRAMING_CRC_CFG_SVH
`define SCF_CLOCK_HZ 100000000
`define SCF_BAUD 115200
`define SCF_BIT_CYCLES (`SCF_CLOCK_HZ / `SCF_BAUD)
`define SCF_FRAME_BITS 11
`define SCF_TIMEOUT_MS 400
`define SCF_TIMEOUT_CYCLES (`SCF_TIMEOUT_MS * (`SCF_CLOCK_HZ / 1000))
`define SCF_APPLY_MS 1
`define SCF_APPLY_CYCLES (`SCF_APPLY_MS * (`SCF_CLOCK_HZ / 1000))
`define SCF_CRC_INIT 16'hFFFF
`define SCF_CRC_POLY 16'hA001
`define SCF_ERRC_CODE 32'h63727265
`define SCF_ERRD_CODE 32'h64727265
`define SCF_ID_BYTES 8'h04
`define SCF_BUF_DEPTH 128
`endif

// File: design/serial_command_framing_crc_pkg.sv
// Types shared by the serial command framing block.
// Assumes the constants header is included by the design file.
package serial_command_framing_crc_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_ID, ST_LOOKUP, ST_DATA, ST_CRC, ST_CHECK, ST_REPLY}
    parse_state_t;
  typedef enum logic [1:0] {RK_ZERO, RK_ECHO, RK_ERRC, RK_ERRD} reply_kind_t;
endpackage : serial_command_framing_crc_pkg

// File: design/serial_command_framing_crc.sv
// Serial command receiver, checker and replier with its own UART.
// Assumes a same-clock executor that looks up identifiers and supplies reply bytes.
`timescale 1ns/1ps
`include "serial_command_framing_crc_cfg.svh"
module serial_command_framing_crc
  import serial_command_framing_crc_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = `SCF_TIMEOUT_CYCLES,
  // Default is the link rate at 100 MHz; a bench may shorten it to keep runs brief
  parameter int BAUD_DIVIDER = `SCF_BIT_CYCLES
)(
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_rx,
  output logic o_tx,
  output logic [31:0] o_lookup_id,
  input wire logic i_id_known,
  input wire logic [7:0] i_id_data_len,
  input wire logic [7:0] i_id_reply_len,
  output logic o_cmd_valid,
  output logic [7:0] o_cmd_len,
  input wire logic [6:0] i_buf_index,
  output logic [7:0] o_buf_byte,
  output logic [7:0] o_reply_index,
  input wire logic [7:0] i_reply_byte,
  input wire logic i_status_clear,
  output logic o_cmd_error,
  output logic o_data_error
);
  localparam logic [9:0] BIT_CYCLES = 10'(BAUD_DIVIDER);
  localparam logic [31:0] TIMEOUT_LAST = 32'(TIMEOUT_CYCLES - 1);

  // =====================================================================
  // Checksum step
  // =====================================================================
  function automatic logic [15:0] checksum_function(input logic [15:0] crc_in,
                                                     input logic [7:0] data);
    logic [15:0] c;
    c = crc_in ^ {8'h00, data};
    for (int j = 0; j < 8; j++)
    begin
      c = c[0] ? ((c >> 1) ^ `SCF_CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction : checksum_function

  // =====================================================================
  // Receiver, 8 data bits framed by start and stop
  // =====================================================================
  logic rx_meta, rx_sync;
  logic rx_busy, next_rx_busy;
  logic [9:0] rx_cnt, next_rx_cnt;
  logic [3:0] rx_bit, next_rx_bit;
  logic [7:0] rx_shift, next_rx_shift;
  logic rx_strobe, next_rx_strobe;

  always_comb
  begin
    next_rx_busy = rx_busy;
    next_rx_cnt = rx_cnt;
    next_rx_bit = rx_bit;
    next_rx_shift = rx_shift;
    next_rx_strobe = 1'b0;
    if (!rx_busy)
    begin
      if (!rx_sync)
      begin
        next_rx_busy = 1'b1;
        next_rx_cnt = BIT_CYCLES >> 1;
        next_rx_bit = 4'h0;
      end
    end
    else if (rx_cnt != 10'h000)
    begin
      next_rx_cnt = rx_cnt - 10'h001;
    end
    else
    begin
      next_rx_cnt = BIT_CYCLES - 10'h001;
      next_rx_bit = rx_bit + 4'h1;
      if (rx_bit == 4'h0)
      begin
        next_rx_busy = !rx_sync;
      end
      else if (rx_bit <= 4'h8)
      begin
        next_rx_shift = {rx_sync, rx_shift[7:1]};
      end
      else
      begin
        // Only the first stop bit is checked so the next start is not missed
        next_rx_busy = 1'b0;
        next_rx_strobe = rx_sync;
      end
    end
  end

  always_ff @(posedge i_clock)
  begin
    rx_meta <= i_rx;
    rx_sync <= rx_meta;
    if (!i_resetn)
    begin
      rx_busy <= 1'b0;
      rx_cnt <= 10'h000;
      rx_bit <= 4'h0;
      rx_shift <= 8'h00;
      rx_strobe <= 1'b0;
    end
    else
    begin
      rx_busy <= next_rx_busy;
      rx_cnt <= next_rx_cnt;
      rx_bit <= next_rx_bit;
      rx_shift <= next_rx_shift;
      rx_strobe <= next_rx_strobe;
    end
  end

  // =====================================================================
  // Transmitter, start + 8 data + 2 stop
  // =====================================================================
  logic tx_go, next_tx_go;
  logic [7:0] tx_data, next_tx_data;
  logic tx_busy, next_tx_busy;
  logic [9:0] tx_cnt, next_tx_cnt;
  logic [3:0] tx_bit, next_tx_bit;
  logic [10:0] tx_shift, next_tx_shift;
  logic next_tx_line;

  always_comb
  begin
    next_tx_busy = tx_busy;
    next_tx_cnt = tx_cnt;
    next_tx_bit = tx_bit;
    next_tx_shift = tx_shift;
    if (!tx_busy)
    begin
      if (tx_go)
      begin
        next_tx_busy = 1'b1;
        next_tx_cnt = BIT_CYCLES - 10'h001;
        next_tx_bit = 4'h0;
        next_tx_shift = {2'b11, tx_data, 1'b0};
      end
    end
    else if (tx_cnt != 10'h000)
    begin
      next_tx_cnt = tx_cnt - 10'h001;
    end
    else
    begin
      next_tx_cnt = BIT_CYCLES - 10'h001;
      next_tx_bit = tx_bit + 4'h1;
      next_tx_shift = {1'b1, tx_shift[10:1]};
      next_tx_busy = (tx_bit != 4'(`SCF_FRAME_BITS - 1));
    end
    next_tx_line = next_tx_busy ? next_tx_shift[0] : 1'b1;
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_resetn)
    begin
      tx_busy <= 1'b0;
      tx_cnt <= 10'h000;
      tx_bit <= 4'h0;
      tx_shift <= 11'h7FF;
      o_tx <= 1'b1;
    end
    else
    begin
      tx_busy <= next_tx_busy;
      tx_cnt <= next_tx_cnt;
      tx_bit <= next_tx_bit;
      tx_shift <= next_tx_shift;
      o_tx <= next_tx_line;
    end
  end

  // =====================================================================
  // Command parser and replier
  // =====================================================================
  parse_state_t state, next_state;
  reply_kind_t kind, next_kind;
  logic [8:0] idx, next_idx;
  logic [8:0] total;
  logic [7:0] dlen, next_dlen;
  logic [7:0] rlen, next_rlen;
  logic [15:0] crc, next_crc;
  logic [15:0] rx_crc, next_rx_crc;
  logic [31:0] tout, next_tout;
  logic [31:0] next_lookup_id;
  logic next_cmd_valid, next_cmd_error, next_data_error;
  logic [7:0] next_reply_index;
  logic buf_we;
  logic [7:0] mem [0:`SCF_BUF_DEPTH-1];
  logic [31:0] word;
  logic rx_byte_zero;

  assign rx_byte_zero = (rx_shift == 8'h00);

  always_comb
  begin
    next_state = state;
    next_kind = kind;
    next_idx = idx;
    next_dlen = dlen;
    next_rlen = rlen;
    next_crc = crc;
    next_rx_crc = rx_crc;
    next_lookup_id = o_lookup_id;
    next_cmd_valid = 1'b0;
    next_tx_go = 1'b0;
    next_tx_data = tx_data;
    buf_we = 1'b0;
    next_cmd_error = o_cmd_error && !i_status_clear;
    next_data_error = o_data_error && !i_status_clear;
    next_tout = (rx_strobe || state == ST_IDLE) ? 32'h0 : tout + 32'h1;
    word = (kind == RK_ERRC) ? `SCF_ERRC_CODE : (kind == RK_ERRD) ? `SCF_ERRD_CODE : o_lookup_id;
    total = (kind == RK_ZERO) ? 9'h001 :
            (kind != RK_ECHO || rlen == 8'h00) ? 9'(`SCF_ID_BYTES) :
            9'(rlen) + 9'h006;
    case (state)
      ST_IDLE:
      begin
        if (rx_strobe && rx_byte_zero)
        begin
          next_kind = RK_ZERO;
          next_idx = 9'h000;
          next_state = ST_REPLY;
        end
        else if (rx_strobe)
        begin
          next_lookup_id = {24'h000000, rx_shift};
          next_idx = 9'h001;
          next_state = ST_ID;
        end
      end
      ST_ID:
      begin
        if (rx_strobe)
        begin
          next_lookup_id[idx[1:0]*8 +: 8] = rx_shift;
          next_idx = idx + 9'h001;
          if (idx == 9'h003)
          begin
            next_state = ST_LOOKUP;
          end
        end
      end
      ST_LOOKUP:
      begin
        next_idx = 9'h000;
        next_dlen = i_id_data_len;
        next_rlen = i_id_reply_len;
        next_crc = `SCF_CRC_INIT;
        if (!i_id_known)
        begin
          // Trailing bytes of an unknown command that arrive during the reply are dropped; later ones are parsed afresh
          next_kind = RK_ERRC;
          next_cmd_error = 1'b1;
          next_state = ST_REPLY;
        end
        else if (i_id_data_len == 8'h00)
        begin
          next_kind = RK_ECHO;
          next_cmd_valid = 1'b1;
          next_state = ST_REPLY;
        end
        else
        begin
          next_state = ST_DATA;
        end
      end
      ST_DATA:
      begin
        if (rx_strobe)
        begin
          buf_we = 1'b1;
          next_crc = checksum_function(crc, rx_shift);
          next_idx = idx + 9'h001;
          if (idx == 9'(dlen) - 9'h001)
          begin
            next_idx = 9'h000;
            next_state = ST_CRC;
          end
        end
      end
      ST_CRC:
      begin
        if (rx_strobe)
        begin
          next_rx_crc[idx[0]*8 +: 8] = rx_shift;
          next_idx = idx + 9'h001;
          if (idx == 9'h001)
          begin
            next_state = ST_CHECK;
          end
        end
      end
      ST_CHECK:
      begin
        next_idx = 9'h000;
        next_crc = `SCF_CRC_INIT;
        if (rx_crc == crc)
        begin
          next_kind = RK_ECHO;
          next_cmd_valid = 1'b1;
        end
        else
        begin
          next_kind = RK_ERRD;
          next_data_error = 1'b1;
        end
        next_state = ST_REPLY;
      end
      default:
      begin
        // Bytes arriving while answering are dropped: the host must wait
        if (!tx_busy && !tx_go)
        begin
          if (idx == total)
          begin
            next_state = ST_IDLE;
            next_idx = 9'h000;
          end
          else
          begin
            next_tx_go = 1'b1;
            next_idx = idx + 9'h001;
            if (kind == RK_ZERO)
            begin
              next_tx_data = 8'h00;
            end
            else if (idx < 9'h004)
            begin
              next_tx_data = word[idx[1:0]*8 +: 8];
            end
            else if (idx < 9'(rlen) + 9'h004)
            begin
              next_tx_data = i_reply_byte;
              next_crc = checksum_function(crc, i_reply_byte);
            end
            else
            begin
              // Low checksum byte first whatever the parity of the reply length
              next_tx_data = crc[{idx[0] ^ rlen[0], 3'b000} +: 8];
            end
          end
        end
      end
    endcase
    if ((state == ST_ID || state == ST_DATA || state == ST_CRC) && !rx_strobe
        && tout == TIMEOUT_LAST)
    begin
      next_state = ST_IDLE;
      next_idx = 9'h000;
      next_lookup_id = 32'h0;
      next_tout = 32'h0;
    end
    next_reply_index = 8'(next_idx - 9'h004);
  end

  always_ff @(posedge i_clock)
  begin
    if (buf_we)
    begin
      mem[idx[6:0]] <= rx_shift;
    end
    o_buf_byte <= mem[i_buf_index];
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_resetn)
    begin
      state <= ST_IDLE;
      kind <= RK_ZERO;
      idx <= 9'h000;
      dlen <= 8'h00;
      rlen <= 8'h00;
      crc <= `SCF_CRC_INIT;
      rx_crc <= 16'h0000;
      tout <= 32'h0;
      o_lookup_id <= 32'h0;
      o_cmd_valid <= 1'b0;
      o_cmd_len <= 8'h00;
      o_cmd_error <= 1'b0;
      o_data_error <= 1'b0;
      o_reply_index <= 8'h00;
      tx_go <= 1'b0;
      tx_data <= 8'h00;
    end
    else
    begin
      state <= next_state;
      kind <= next_kind;
      idx <= next_idx;
      dlen <= next_dlen;
      rlen <= next_rlen;
      crc <= next_crc;
      rx_crc <= next_rx_crc;
      tout <= next_tout;
      o_lookup_id <= next_lookup_id;
      o_cmd_valid <= next_cmd_valid;
      o_cmd_len <= next_dlen;
      o_cmd_error <= next_cmd_error;
      o_data_error <= next_data_error;
      o_reply_index <= next_reply_index;
      tx_go <= next_tx_go;
      tx_data <= next_tx_data;
    end
  end

  // =====================================================================
  // Checks
  // =====================================================================
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_resetn);

  start_bit_low_a: assert property ($rose(tx_busy) |-> !o_tx [*8])
    else $error("start bit not held low");
  stop_bits_high_a: assert property (tx_busy && tx_bit >= 4'h9 |-> o_tx)
    else $error("stop bit not high");
  zero_answer_a: assert property (state == ST_IDLE && rx_strobe && rx_byte_zero
    |=> state == ST_REPLY && kind == RK_ZERO)
    else $error("zero first byte not answered with zero");
  unknown_cmd_a: assert property (state == ST_LOOKUP && !i_id_known
    |=> kind == RK_ERRC && o_cmd_error && !o_cmd_valid)
    else $error("unknown identifier not flagged");
  bad_crc_a: assert property (state == ST_CHECK && rx_crc != crc
    |=> kind == RK_ERRD && o_data_error && !o_cmd_valid)
    else $error("checksum mismatch not flagged");
  exec_gate_a: assert property (o_cmd_valid |-> ($past(state) == ST_LOOKUP && $past(i_id_known)
    && $past(i_id_data_len) == 8'h00) || ($past(state) == ST_CHECK
    && $past(rx_crc) == $past(crc)))
    else $error("command released without valid check");
  ack_on_exec_a: assert property (o_cmd_valid |-> state == ST_REPLY && kind == RK_ECHO
    ##1 !o_cmd_valid)
    else $error("execution pulse without echo");
  timeout_drop_a: assert property (state == ST_ID && tout == TIMEOUT_LAST && !rx_strobe
    |=> state == ST_IDLE && o_lookup_id == 32'h0)
    else $error("partial command survived timeout");
  flag_hold_a: assert property (o_cmd_error && !i_status_clear |=> o_cmd_error)
    else $error("command error flag lost");
endmodule : serial_command_framing_crc

// File: verification/host_link_model.sv
// Host side of the serial command link: sends bytes and collects replies.
// Assumes the device clock drives the bit timing and the line idles high.
`timescale 1ns/1ps
`include "serial_command_framing_crc_cfg.svh"
module host_link_model #(
  parameter int BIT = `SCF_BIT_CYCLES
)(
  input wire logic i_clock,
  input wire logic i_tx,
  output logic o_rx
);
  localparam int FRAME = BIT * `SCF_FRAME_BITS;
  logic [7:0] rx_q[$];
  int bad_frames = 0;

  initial o_rx = 1'b1;

  // ==========================================================
  // Transmit: start, 8 data LSB first, 2 stop bits, no parity
  // ==========================================================
  task automatic send_byte(input logic [7:0] b);
    logic [10:0] frame;
    frame = {2'b11, b, 1'b0};
    for (int i = 0; i < 11; i++)
    begin
      o_rx <= frame[i];
      repeat (BIT) @(posedge i_clock);
    end
  endtask : send_byte

  // ==========================================================
  // Zero-byte resynchronisation; lost is high when no zero returns
  // ==========================================================
  function automatic logic zero_seen();
    while (rx_q.size() > 0)
    begin
      if (rx_q.pop_front() == 8'h00)
        return 1'b1;
    end
    return 1'b0;
  endfunction : zero_seen

  task automatic resync(input int wait_cycles, output logic lost);
    int w;
    lost = 1'b1;
    @(posedge i_clock);
    for (int burst = 0; burst < 4 && lost; burst++)
    begin
      for (int k = 0; k < 64 && lost; k++)
      begin
        send_byte(8'h00);
        lost = !zero_seen();
      end
      w = 0;
      while (lost && w < wait_cycles)
      begin
        @(posedge i_clock);
        w++;
        lost = !zero_seen();
      end
    end
    // Zeros still in transit arrive before any reply and are dropped
    repeat (2 * FRAME) @(posedge i_clock);
    while (rx_q.size() > 0 && rx_q[0] == 8'h00)
      void'(rx_q.pop_front());
  endtask : resync

  // ==========================================================
  // Receive: sample mid-bit, both stop bits must be high
  // ==========================================================
  always
  begin : rx_proc
    logic [7:0] b;
    @(negedge i_tx);
    repeat (BIT / 2) @(posedge i_clock);
    if (i_tx === 1'b0)
    begin
      for (int i = 0; i < 8; i++)
      begin
        repeat (BIT) @(posedge i_clock);
        b[i] = i_tx;
      end
      repeat (BIT) @(posedge i_clock);
      if (i_tx !== 1'b1)
        bad_frames++;
      repeat (BIT) @(posedge i_clock);
      if (i_tx !== 1'b1)
        bad_frames++;
      rx_q.push_back(b);
    end
  end
endmodule : host_link_model

// File: verification/tb.sv
// Self-checking bench for the serial command framing block.
// Assumes two known commands: one with a data byte and a reply byte, one bare.
`timescale 1ns/1ps
`include "serial_command_framing_crc_cfg.svh"
module tb;
  import serial_command_framing_crc_pkg::*;
  typedef logic [7:0] bytes_t[$];
  localparam int TO = 1000;
  // A short bit time keeps the 256-zero lost-device case inside the cycle budget
  localparam int BIT = 16;
  localparam int FRAME = BIT * `SCF_FRAME_BITS;
  localparam int LIMIT = 90000;
  localparam logic [31:0] ID_CMD = 32'h736F7067;
  localparam logic [31:0] ID_BARE = 32'h6C6C6F70;
  logic clock = 1'b0;
  logic resetn, rx, tx, id_known, cmd_valid, status_clear, cmd_error, data_error;
  logic [31:0] lookup_id;
  logic [7:0] cmd_len, buf_byte, reply_index, reply_byte, data_len, reply_len;
  logic lost;
  logic [6:0] buf_index;
  int n_errors = 0;
  int n_checks = 0;
  int n_valid = 0;
  int cycles = 0;
  logic [31:0] id;
  logic [7:0] d;
  logic [15:0] c;
  bytes_t b;

  always #5 clock = ~clock;

  serial_command_framing_crc #(.TIMEOUT_CYCLES(TO), .BAUD_DIVIDER(BIT)) dut_u (
    .i_clock(clock), .i_resetn(resetn), .i_rx(rx), .o_tx(tx),
    .o_lookup_id(lookup_id), .i_id_known(id_known), .i_id_data_len(data_len),
    .i_id_reply_len(reply_len), .o_cmd_valid(cmd_valid), .o_cmd_len(cmd_len),
    .i_buf_index(buf_index), .o_buf_byte(buf_byte), .o_reply_index(reply_index),
    .i_reply_byte(reply_byte), .i_status_clear(status_clear),
    .o_cmd_error(cmd_error), .o_data_error(data_error)
  );

  host_link_model #(.BIT(BIT)) host_u (.i_clock(clock), .i_tx(tx), .o_rx(rx));

  // ==========================================================
  // Executor stand-in; combinational because the lookup lasts one cycle
  // ==========================================================
  always_comb
  begin
    id_known = (lookup_id === ID_CMD) || (lookup_id === ID_BARE);
    data_len = (lookup_id === ID_CMD) ? 8'h01 : 8'h00;
    reply_len = (lookup_id === ID_CMD) ? 8'h01 : 8'h00;
    reply_byte = reply_index ^ 8'h5A;
  end

  always @(posedge clock)
  begin
    if (cmd_valid === 1'b1)
      n_valid++;
    cycles++;
    if (cycles == LIMIT)
    begin
      n_errors++;
      test_done();
    end
  end

  // ==========================================================
  // Helpers
  // ==========================================================
  function automatic logic [15:0] checksum_function(input bytes_t v);
    logic [15:0] r;
    r = 16'hFFFF;
    foreach (v[i])
    begin
      r = r ^ {8'h00, v[i]};
      for (int j = 0; j < 8; j++)
        r = r[0] ? ((r >> 1) ^ 16'hA001) : (r >> 1);
    end
    return r;
  endfunction : checksum_function

  function automatic bytes_t id_bytes(input logic [31:0] v);
    return '{v[7:0], v[15:8], v[23:16], v[31:24]};
  endfunction : id_bytes

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic send_frame(input bytes_t v);
    @(posedge clock);
    foreach (v[i])
      host_u.send_byte(v[i]);
  endtask : send_frame

  task automatic expect_reply(input bytes_t e);
    int w;
    logic [31:0] got;
    foreach (e[i])
    begin
      w = 0;
      // Reply wait exceeds the device byte timeout plus a transfer
      while (host_u.rx_q.size() == 0 && w < TO + 2 * FRAME)
      begin
        @(posedge clock);
        w++;
      end
      got = 32'hFFFF_FFFF;
      if (host_u.rx_q.size() > 0)
        got = {24'h0, host_u.rx_q.pop_front()};
      check(got, {24'h0, e[i]});
    end
  endtask : expect_reply

  task automatic check_flags(input logic ce, input logic de);
    #1;
    check({31'h0, cmd_error}, {31'h0, ce});
    check({31'h0, data_error}, {31'h0, de});
  endtask : check_flags

  task automatic clear_flags();
    @(posedge clock);
    status_clear <= 1'b1;
    @(posedge clock);
    status_clear <= 1'b0;
    @(posedge clock);
    check_flags(1'b0, 1'b0);
  endtask : clear_flags

  task automatic end_test(input string name);
    $display("test %s finished", name);
  endtask : end_test

  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : test_done

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial
  begin
    resetn = 1'b0;
    status_clear = 1'b0;
    buf_index = 7'h00;
    void'($urandom(32'h1861));
    repeat (6) @(posedge clock);
    resetn <= 1'b1;
    #1;
    check({31'h0, tx}, 32'h1);
    check(lookup_id, 32'h0);
    check_flags(1'b0, 1'b0);
    end_test("reset");

    // Partial identifier is dropped, then a zero byte gets one zero back
    b = id_bytes(ID_CMD);
    send_frame(b[0:1]);
    repeat (TO + 2 * BIT) @(posedge clock);
    check(host_u.rx_q.size(), 32'h0);
    check(lookup_id, 32'h0);
    send_frame('{8'h00});
    expect_reply('{8'h00});
    repeat (2 * FRAME) @(posedge clock);
    check(host_u.rx_q.size(), 32'h0);
    end_test("timeout_zero");

    // Unknown identifier
    id = $urandom;
    id[7:0] = id[7:0] | 8'h01;
    if (id == ID_CMD)
      id = id ^ 32'h0000_0100;
    send_frame(id_bytes(id));
    expect_reply('{8'h65, 8'h72, 8'h72, 8'h63});
    check_flags(1'b1, 1'b0);
    check(n_valid, 32'h0);
    host_u.resync(TO + 2 * FRAME, lost);
    check({31'h0, lost}, 32'h0);
    clear_flags();
    end_test("unknown_id");

    // Known identifier with a corrupted checksum
    d = $urandom;
    c = checksum_function('{d}) ^ 16'h0001;
    b = id_bytes(ID_CMD);
    b.push_back(d);
    b.push_back(c[7:0]);
    b.push_back(c[15:8]);
    send_frame(b);
    expect_reply('{8'h65, 8'h72, 8'h72, 8'h64});
    check_flags(1'b0, 1'b1);
    check(n_valid, 32'h0);
    clear_flags();
    end_test("bad_checksum");

    // Silent device: reply timeout, four bursts find no zero, then reset recovery
    @(posedge clock);
    resetn <= 1'b0;
    send_frame(id_bytes(ID_BARE));
    repeat (TO + 2 * FRAME) @(posedge clock);
    check(host_u.rx_q.size(), 32'h0);
    host_u.resync(TO + 2 * FRAME, lost);
    check({31'h0, lost}, 32'h1);
    @(posedge clock);
    resetn <= 1'b1;
    #1;
    check({31'h0, tx}, 32'h1);
    check(lookup_id, 32'h0);
    check_flags(1'b0, 1'b0);
    send_frame(id_bytes(ID_BARE));
    expect_reply(id_bytes(ID_BARE));
    check(n_valid, 32'h1);
    end_test("lost_and_reset");

    // Good command: echo, reply data, reply checksum low byte first
    d = $urandom;
    c = checksum_function('{d});
    b = id_bytes(ID_CMD);
    b.push_back(d);
    b.push_back(c[7:0]);
    b.push_back(c[15:8]);
    send_frame(b);
    c = checksum_function('{8'h5A});
    b = id_bytes(ID_CMD);
    b.push_back(8'h5A);
    b.push_back(c[7:0]);
    b.push_back(c[15:8]);
    expect_reply(b);
    check(n_valid, 32'h2);
    check({24'h0, cmd_len}, 32'h1);
    @(posedge clock);
    buf_index <= 7'h00;
    repeat (2) @(posedge clock);
    #1;
    check({24'h0, buf_byte}, {24'h0, d});
    check_flags(1'b0, 1'b0);
    check(host_u.bad_frames, 32'h0);
    check(host_u.rx_q.size(), 32'h0);
    end_test("good_command");
    test_done();
  end
endmodule : tb
